// file: hdl/window_pkg.sv
// Constants, states and timing for the power window controller.
// Assumes a single 250 MHz system clock.
package window_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_WINDOWS = 4;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int EXPRESS_HOLD_MS = 300;
  localparam int EXPRESS_HOLD_CYCLES = EXPRESS_HOLD_MS * 1000 * CLK_MHZ;
  localparam int LOCK_TIMEOUT_MS = 100;
  localparam int LOCK_TIMEOUT_CYCLES = LOCK_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W = 27;

  // ==========================================================
  // Per-window mode
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RAISE = 3'b001,
    ST_LOWER = 3'b010,
    ST_EXPRESS = 3'b011,
    ST_WAIT_RELEASE = 3'b100,
    ST_STOP_GAP = 3'b101
  } win_state_t;

  // ==========================================================
  // Reset values
  localparam logic RST_DRIVE = 1'b0;
  localparam logic [TIMER_W-1:0] RST_TIMER = 27'h0000000;

endpackage

// file: hdl/window_channel.sv
// One window's sequencer: switch modes, cranking, lock-current cutoff.
// Assumes switch and lock inputs are already synchronised, active high.
`timescale 1ns/1ps
`default_nettype none
module window_channel #(
  parameter int HOLD_CYCLES = window_pkg::EXPRESS_HOLD_CYCLES,
  parameter int LOCK_CYCLES = window_pkg::LOCK_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Conditions
  input wire logic run_ok,
  input wire logic cranking,
  // Switch requests
  input wire logic manual_raise_req,
  input wire logic manual_lower_req,
  input wire logic auto_lower_req,
  // Motor feedback
  input wire logic lock_current,
  // Motor drives
  output logic motor_up,
  output logic motor_down
);
  import window_pkg::*;

  typedef struct packed {
    win_state_t st;
    logic [TIMER_W-1:0] hold;
    logic [TIMER_W-1:0] lock;
    logic express_resume;
    logic up;
    logic down;
  } chan_t;

  chan_t cur;
  chan_t next_cur;

  // ==========================================================
  // Sequencer
  always_comb begin
    logic any_req;
    logic want_up;
    logic want_down;
    any_req = manual_raise_req | manual_lower_req;
    next_cur = cur;
    want_up = 1'b0;
    want_down = 1'b0;
    unique case (cur.st)
      ST_IDLE: begin
        next_cur.hold = RST_TIMER;
        next_cur.lock = RST_TIMER;
        if (run_ok && !cranking) begin
          if (manual_raise_req && !manual_lower_req) begin
            next_cur.st = ST_RAISE;
          end else if (manual_lower_req && !manual_raise_req) begin
            next_cur.st = ST_LOWER;
          end
        end
      end
      ST_RAISE: begin
        if (!manual_raise_req || manual_lower_req) begin
          next_cur.st = ST_STOP_GAP;
        end else begin
          want_up = !cranking;
        end
      end
      ST_LOWER: begin
        if (!manual_lower_req || manual_raise_req) begin
          next_cur.st = ST_STOP_GAP;
        end else begin
          want_down = !cranking;
          // Both lines low beyond the threshold latch express lower
          if (auto_lower_req && !cranking) begin
            if (cur.hold >= TIMER_W'(HOLD_CYCLES)) begin
              next_cur.st = ST_EXPRESS;
              next_cur.express_resume = 1'b0;
            end else begin
              next_cur.hold = cur.hold + 1'b1;
            end
          end else if (!auto_lower_req) begin
            next_cur.hold = RST_TIMER;
          end
        end
      end
      ST_EXPRESS: begin
        // A press only cancels once the launching press is let go
        if (!any_req) begin
          next_cur.express_resume = 1'b1;
        end
        if (cur.express_resume && any_req) begin
          next_cur.st = ST_WAIT_RELEASE;
        end else begin
          want_down = !cranking;
        end
      end
      ST_WAIT_RELEASE: begin
        if (!any_req) begin
          next_cur.st = ST_IDLE;
        end
      end
      ST_STOP_GAP: begin
        // Fresh press needed; also one idle cycle between directions
        next_cur.st = any_req ? ST_WAIT_RELEASE : ST_IDLE;
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
    // Lock current cuts drive after the timeout in every moving mode
    if ((want_up || want_down) && lock_current) begin
      if (cur.lock >= TIMER_W'(LOCK_CYCLES)) begin
        want_up = 1'b0;
        want_down = 1'b0;
        next_cur.st = ST_WAIT_RELEASE;
      end else begin
        next_cur.lock = cur.lock + 1'b1;
      end
    end else begin
      next_cur.lock = RST_TIMER;
    end
    // Ignition loss ends any motion
    if (!run_ok && cur.st != ST_IDLE) begin
      want_up = 1'b0;
      want_down = 1'b0;
      next_cur.st = ST_STOP_GAP;
    end
    // Never reverse without a stopped cycle
    next_cur.up = want_up && !cur.down;
    next_cur.down = want_down && !cur.up;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '{st: ST_IDLE, hold: RST_TIMER, lock: RST_TIMER, express_resume: 1'b0,
               up: RST_DRIVE, down: RST_DRIVE};
    end else begin
      cur <= next_cur;
    end
  end

  assign motor_up = cur.up;
  assign motor_down = cur.down;

endmodule
`default_nettype wire

// file: hdl/power_window_control.sv
// Top of the power window controller: pin synchronisers and four channels.
// Assumes switch lines are active-low grounds, ignition/crank/lock active high.
`timescale 1ns/1ps
`default_nettype none
module power_window_control #(
  parameter int EXPRESS_CYCLES = window_pkg::EXPRESS_HOLD_CYCLES,
  parameter int LOCK_CYCLES = window_pkg::LOCK_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Vehicle state
  input wire logic ignition,
  input wire logic cranking,
  // Switch mode lines, active low
  input wire logic [window_pkg::NUM_WINDOWS-1:0] manual_raise_req_n,
  input wire logic [window_pkg::NUM_WINDOWS-1:0] manual_lower_req_n,
  input wire logic [window_pkg::NUM_WINDOWS-1:0] auto_lower_req_n,
  // Lock current comparator per window
  input wire logic [window_pkg::NUM_WINDOWS-1:0] lock_current,
  // Motor drives
  output logic [window_pkg::NUM_WINDOWS-1:0] motor_up,
  output logic [window_pkg::NUM_WINDOWS-1:0] motor_down
);
  import window_pkg::*;

  localparam int IN_W = 3 * NUM_WINDOWS + NUM_WINDOWS + 2;

  // ==========================================================
  // Input synchronisers: stage 1 feeds only stage 2
  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic [IN_W-1:0] clean;
  } sync_t;

  sync_t sy;
  sync_t next_sy;
  logic [IN_W-1:0] raw;

  assign raw = {~manual_raise_req_n, ~manual_lower_req_n, ~auto_lower_req_n, lock_current, ignition, cranking};

  always_comb begin
    next_sy = sy;
    next_sy.s1 = raw;
    next_sy.s2 = sy.s1;
    next_sy.s3 = sy.s2;
    // A change counts once the second and third stages agree
    next_sy.clean = (sy.s2 & sy.s3) | (sy.clean & (sy.s2 | sy.s3));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sy <= '0;
    end else begin
      sy <= next_sy;
    end
  end

  logic [NUM_WINDOWS-1:0] up_c;
  logic [NUM_WINDOWS-1:0] dn_c;
  logic [NUM_WINDOWS-1:0] al_c;
  logic [NUM_WINDOWS-1:0] lk_c;
  logic ign_c;
  logic crk_c;

  assign {up_c, dn_c, al_c, lk_c, ign_c, crk_c} = sy.clean;

  // ==========================================================
  // Independent channels; outputs are channel flip-flops
  for (genvar w = 0; w < NUM_WINDOWS; w++) begin : g_win
    window_channel #(
      .HOLD_CYCLES(EXPRESS_CYCLES),
      .LOCK_CYCLES(LOCK_CYCLES)
    ) u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .run_ok(ign_c),
      .cranking(crk_c),
      .manual_raise_req(up_c[w]),
      .manual_lower_req(dn_c[w]),
      .auto_lower_req(al_c[w] & dn_c[w]),
      .lock_current(lk_c[w]),
      .motor_up(motor_up[w]),
      .motor_down(motor_down[w])
    );
  end

endmodule
`default_nettype wire

// file: tb/pwc_chk.sv
// Checker for the power window controller top ports.
// Assumes one clock domain and the top's own parameters.
`timescale 1ns/1ps
`default_nettype none
module pwc_chk
  import window_pkg::*;
#(
  parameter int EXPRESS_CYCLES = 30,
  parameter int LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Vehicle and switches
  input wire logic ignition,
  input wire logic cranking,
  input wire logic [NUM_WINDOWS-1:0] manual_raise_req_n,
  input wire logic [NUM_WINDOWS-1:0] manual_lower_req_n,
  input wire logic [NUM_WINDOWS-1:0] auto_lower_req_n,
  input wire logic [NUM_WINDOWS-1:0] lock_current,
  // Drives
  input wire logic [NUM_WINDOWS-1:0] motor_up,
  input wire logic [NUM_WINDOWS-1:0] motor_down
);
  // ==========================================================
  // Stall time of window 0 while driven
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] lk;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lk <= '0;
    end else if (lock_current[0] && (motor_up[0] || motor_down[0])) begin
      lk <= lk + 32'h1;
    end else begin
      lk <= '0;
    end
  end
  property p_excl; (motor_up & motor_down) == '0; endproperty
  a_excl: assert property (p_excl) else $error("up and down together");
  property p_gap; ((motor_up & $past(motor_down)) | (motor_down & $past(motor_up))) == '0; endproperty
  a_gap: assert property (p_gap) else $error("reversal without stop");
  property p_ign; !ignition [*8] |-> (motor_up | motor_down) == '0; endproperty
  a_ign: assert property (p_ign) else $error("drive with ignition off");
  property p_crank; cranking [*8] |-> (motor_up | motor_down) == '0; endproperty
  a_crank: assert property (p_crank) else $error("drive while cranking");
  // Sync and drive latency add a few cycles to the timeout
  property p_lock; lk <= LOCK_CYCLES + 8; endproperty
  a_lock: assert property (p_lock) else $error("stall not cut off");
  property p_up_only; (manual_raise_req_n == '1) [*8] |-> motor_up == '0; endproperty
  a_up_only: assert property (p_up_only) else $error("up drive without request");
  property p_up_go; (manual_raise_req_n[0] && !motor_down[0] && ignition && !cranking && !lock_current[0]) [*5]
    ##1 (!manual_raise_req_n[0] && manual_lower_req_n[0] && auto_lower_req_n[0] && ignition && !cranking
    && !lock_current[0]) [*8] |-> motor_up[0]; endproperty
  a_up_go: assert property (p_up_go) else $error("held up gives no drive");
  property p_dn_go; (manual_lower_req_n[0] && !motor_up[0] && ignition && !cranking && !lock_current[0]) [*5]
    ##1 (!manual_lower_req_n[0] && manual_raise_req_n[0] && ignition && !cranking && !lock_current[0]) [*8]
    |-> motor_down[0]; endproperty
  a_dn_go: assert property (p_dn_go) else $error("held down gives no drive");
endmodule
bind power_window_control pwc_chk #(.EXPRESS_CYCLES(EXPRESS_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .clk_sys, .rst, .ignition, .cranking, .manual_raise_req_n, .manual_lower_req_n, .auto_lower_req_n,
  .lock_current, .motor_up, .motor_down);
`default_nettype wire

// file: tb/window_plant.sv
// Lift motors and current sensing for all windows.
// Assumes end of travel shows only as stall current.
`timescale 1ns/1ps
`default_nettype none
module window_plant
  import window_pkg::*;
#(
  parameter int TRAVEL = 200
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Drives and stall sense
  input wire logic [NUM_WINDOWS-1:0] motor_up,
  input wire logic [NUM_WINDOWS-1:0] motor_down,
  output logic [NUM_WINDOWS-1:0] lock_current
);
  // ==========================================================
  // Glass position, one step per driven cycle
  int pos [NUM_WINDOWS];
  always @(posedge clk_sys or posedge rst) begin
    for (int i = 0; i < NUM_WINDOWS; i++) begin
      if (rst) begin
        pos[i] <= TRAVEL / 2;
      end else if (motor_up[i] && pos[i] < TRAVEL) begin
        pos[i] <= pos[i] + 1;
      end else if (motor_down[i] && pos[i] > 0) begin
        pos[i] <= pos[i] - 1;
      end
    end
  end
  // Stalled motor draws locking current only while still driven
  always_comb begin
    for (int i = 0; i < NUM_WINDOWS; i++) begin
      lock_current[i] = (motor_up[i] && pos[i] == TRAVEL) || (motor_down[i] && pos[i] == 0);
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the power window controller.
// Assumes short timing parameters; window 0 carries most scenarios.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import window_pkg::*;
  // ==========================================================
  // Stimulus and checking
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ignition = 1'b0;
  logic cranking = 1'b0;
  logic [NUM_WINDOWS-1:0] manual_raise_req_n = '1;
  logic [NUM_WINDOWS-1:0] manual_lower_req_n = '1;
  logic [NUM_WINDOWS-1:0] auto_lower_req_n = '1;
  logic [NUM_WINDOWS-1:0] lock_current;
  logic [NUM_WINDOWS-1:0] motor_up;
  logic [NUM_WINDOWS-1:0] motor_down;
  logic [31:0] seed = 32'hE7A93F96;
  int n_mismatch = 0;
  int n_tests = 0;
  int ow;
  initial forever #2 clk_sys = ~clk_sys;
  power_window_control #(.EXPRESS_CYCLES(30), .LOCK_CYCLES(20)) u_dut (.clk_sys, .rst, .ignition, .cranking,
    .manual_raise_req_n, .manual_lower_req_n, .auto_lower_req_n, .lock_current, .motor_up, .motor_down);
  window_plant u_plant (.clk_sys, .rst, .motor_up, .motor_down, .lock_current);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic sw(input logic u, input logic d, input logic a, input int n);
    manual_raise_req_n[0] = ~u;
    manual_lower_req_n[0] = ~d;
    auto_lower_req_n[0] = ~a;
    cyc(n);
  endtask
  task automatic chk(input int w, input logic eu, input logic ed);
    n_tests++;
    if (motor_up[w] !== eu || motor_down[w] !== ed) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, {eu, ed}, {motor_up[w], motor_down[w]});
    end
    $display("test %0d ends", n_tests);
  endtask
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Timeout is several times the expected run length
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
  initial begin
    cyc(2);
    rst = 1'b0;
    seed = xs(seed);
    ow = 1 + int'(seed % 32'd3);
    cyc(2);
    chk(0, 0, 0);
    sw(1, 0, 0, 20);
    chk(0, 0, 0);
    sw(0, 0, 0, 5);
    ignition = 1'b1;
    manual_lower_req_n[ow] = 1'b0;
    sw(1, 0, 0, 10);
    chk(0, 1, 0);
    chk(ow, 0, 1);
    manual_lower_req_n[ow] = 1'b1;
    cranking = 1'b1;
    cyc(10);
    chk(ow, 0, 0);
    chk(0, 0, 0);
    cranking = 1'b0;
    cyc(10);
    chk(0, 1, 0);
    sw(0, 0, 0, 10);
    chk(0, 0, 0);
    sw(1, 0, 0, 150);
    chk(0, 0, 0);
    sw(0, 0, 0, 5);
    sw(1, 0, 0, 12);
    chk(0, 1, 0);
    sw(1, 0, 0, 48);
    chk(0, 0, 0);
    sw(0, 0, 0, 5);
    sw(0, 1, 1, 45);
    sw(0, 0, 0, 10);
    chk(0, 0, 1);
    cranking = 1'b1;
    cyc(20);
    chk(0, 0, 0);
    cranking = 1'b0;
    cyc(10);
    chk(0, 0, 1);
    sw(1, 0, 0, 10);
    chk(0, 0, 0);
    cyc(20);
    chk(0, 0, 0);
    sw(0, 0, 0, 5);
    sw(1, 0, 0, 10);
    chk(0, 1, 0);
    sw(0, 0, 0, 5);
    sw(0, 1, 1, 40);
    sw(0, 0, 0, 20);
    chk(0, 0, 1);
    sw(0, 0, 0, 280);
    chk(0, 0, 0);
    sw(0, 1, 0, 12);
    chk(0, 0, 1);
    sw(0, 1, 0, 28);
    chk(0, 0, 0);
    sw(0, 0, 0, 5);
    sw(0, 1, 1, 12);
    chk(0, 0, 1);
    sw(0, 1, 1, 28);
    chk(0, 0, 0);
    conclude();
  end
endmodule
`default_nettype wire
